//--- verilog/qrl_flash_cmd.sv
// Serial flash command interpreter: read parameters, wrapped burst, quad mode, block locks
// How it works
// - Quad mode accepts read-parameter command, sets both
// - Serial mode rejects read-parameter command
// - Serial mode: fixed dummies, wrap from 77h
// - Reset defaults: 8-byte wrap, 2 dummies
// - Dummy field 00/01/10/11 gives 2/4/6/8
// - Wrap field 00/01/10/11 gives 8/16/32/64
// - Wrapped burst wraps inside aligned window
// - One mode at once; only 38h enters quad
// - Power-up in serial mode
// - Enter quad only with quad-enable set
// - Entering quad keeps latch and wrap
// - Exit command returns to serial mode
// - Leaving quad keeps latch and wrap
// - Lock bits govern only when scheme select set
// - Lock bits volatile, all set after reset
// - Lock command sets addressed bit if latch set
// - Unlock command clears addressed bit if latch set
// - Read-lock shifts out byte, LSB is lock
// - Global lock sets all bits, needs latch
// - Global unlock clears all bits, needs latch
// - Reset sequence restores volatile defaults
`include "qrl_cfg.svh"

module qrl_flash_cmd #(
  parameter int LOCK_IDX_W = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins from the host
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe_n,
  // Array read port
  output logic      [23:0] array_addr,
  input  wire logic [7:0]  array_rd_data,
  // Protection query from the program/erase side
  input  wire logic [23:0] prot_addr,
  input  wire logic        legacy_protected,
  output logic             prot_locked,
  output logic      [6:0]  legacy_prot_cfg
);

  localparam int NUM_LOCKS = 1 << LOCK_IDX_W;

  // Pin synchronisers; first stage feeds only the second
  logic       cs_n_s1, cs_n_s2, cs_n_d;
  logic       sclk_s1, sclk_s2, sclk_d;
  logic [3:0] io_s1, io_s2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      cs_n_d  <= 1'b1;
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_d  <= 1'b0;
      io_s1   <= 4'h0;
      io_s2   <= 4'h0;
    end else begin
      cs_n_s1 <= cs_n_pin;
      cs_n_s2 <= cs_n_s1;
      cs_n_d  <= cs_n_s2;
      sclk_s1 <= sclk_pin;
      sclk_s2 <= sclk_s1;
      sclk_d  <= sclk_s2;
      io_s1   <= io_in;
      io_s2   <= io_s1;
    end
  end

  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  assign sclk_rise = !cs_n_s2 && sclk_s2 && !sclk_d;
  assign sclk_fall = !cs_n_s2 && !sclk_s2 && sclk_d;
  assign cs_rise   = cs_n_s2 && !cs_n_d;
  assign cs_fall   = !cs_n_s2 && cs_n_d;

  // Settings state
  logic                 quad_instruction_mode_reg;
  logic                 write_enable_latch_reg;
  logic                 reset_enable_reg;
  logic [1:0]           dummy_cycle_field_reg;
  logic [1:0]           wrap_length_reg;
  logic [NUM_LOCKS-1:0] lock_reg;
  logic [7:0]           ctrl_reg;
  logic [LOCK_IDX_W-1:0] lock_sel_reg;

  logic quad_enable_bit, protection_scheme_select;
  assign quad_enable_bit          = ctrl_reg[`QRL_CTRL_QUAD_EN];
  assign protection_scheme_select = ctrl_reg[`QRL_CTRL_SCHEME];

  // Frame state
  qrl_pkg::qrl_state_t state_reg;
  logic [7:0]  cmd_reg;
  logic [31:0] sh_reg;
  logic [5:0]  bit_cnt_reg;
  logic [3:0]  dummy_left_reg;
  logic [23:0] addr_reg;
  logic [2:0]  out_left_reg;
  logic [7:0]  out_sh_reg;

  logic       wide_in, wide_out, load_byte;
  logic [2:0] in_w;
  logic [5:0] bit_cnt_next;
  logic [31:0] sh_next;
  logic [7:0] cmd_byte;
  logic [3:0] dummy_eff;
  logic [6:0] wrap_bytes;
  logic [5:0] wrap_mask;
  logic [23:0] addr_inc;

  assign wide_in = quad_instruction_mode_reg ||
                   (state_reg == qrl_pkg::QRL_ADDR && cmd_reg == `QRL_CMD_QUAD_IO);
  assign wide_out = quad_instruction_mode_reg || cmd_reg == `QRL_CMD_QUAD_IO;
  assign in_w = wide_in ? 3'd4 : 3'd1;
  assign bit_cnt_next = bit_cnt_reg + {3'd0, in_w};
  assign sh_next = wide_in ? {sh_reg[27:0], io_s2} : {sh_reg[30:0], io_s2[0]};
  assign cmd_byte = sh_next[7:0];
  assign load_byte = sclk_fall && state_reg == qrl_pkg::QRL_DATA && out_left_reg == 3'd0;

  // Programmable dummies only in quad mode, fixed otherwise
  always_comb begin
    if (quad_instruction_mode_reg) begin
      dummy_eff = `QRL_DUMMY_BASE + {1'b0, dummy_cycle_field_reg, 1'b0};
    end else if (cmd_reg == `QRL_CMD_QUAD_IO) begin
      dummy_eff = `QRL_SPI_QIO_DUMMY;
    end else begin
      dummy_eff = `QRL_SPI_FAST_DUMMY;
    end
  end

  assign wrap_bytes = `QRL_WRAP_BASE << wrap_length_reg;
  assign wrap_mask  = 6'(wrap_bytes - 7'd1);

  // Wrapped burst stays inside the aligned window
  always_comb begin
    addr_inc = addr_reg + 24'h000001;
    if (cmd_reg == `QRL_CMD_WRAP_READ) begin
      addr_inc = {addr_reg[23:6], (addr_reg[5:0] & ~wrap_mask) | (6'(addr_reg[5:0] + 6'h01) & wrap_mask)};
    end
  end

  // Frame sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= qrl_pkg::QRL_IDLE;
      cmd_reg        <= 8'h00;
      sh_reg         <= 32'h0000_0000;
      bit_cnt_reg    <= 6'd0;
      dummy_left_reg <= 4'd0;
      addr_reg       <= 24'h000000;
    end else if (cs_n_s2) begin
      state_reg   <= qrl_pkg::QRL_IDLE;
      bit_cnt_reg <= 6'd0;
    end else if (cs_fall) begin
      state_reg   <= qrl_pkg::QRL_CMD;
      bit_cnt_reg <= 6'd0;
    end else if (load_byte && cmd_reg != `QRL_CMD_READ_LOCK) begin
      addr_reg <= addr_inc;
    end else if (sclk_rise) begin
      sh_reg      <= sh_next;
      bit_cnt_reg <= bit_cnt_next;
      unique case (state_reg)
        qrl_pkg::QRL_CMD: begin
          if (bit_cnt_next == `QRL_CMD_BITS) begin
            cmd_reg     <= cmd_byte;
            bit_cnt_reg <= 6'd0;
            unique case (cmd_byte)
              `QRL_CMD_FAST_READ, `QRL_CMD_QUAD_IO, `QRL_CMD_LOCK, `QRL_CMD_UNLOCK,
              `QRL_CMD_READ_LOCK: state_reg <= qrl_pkg::QRL_ADDR;
              `QRL_CMD_WRAP_READ:
                state_reg <= quad_instruction_mode_reg ? qrl_pkg::QRL_ADDR : qrl_pkg::QRL_IGNORE;
              `QRL_CMD_SET_PARAM:
                state_reg <= quad_instruction_mode_reg ? qrl_pkg::QRL_PARAM : qrl_pkg::QRL_IGNORE;
              `QRL_CMD_SET_WRAP:
                state_reg <= quad_instruction_mode_reg ? qrl_pkg::QRL_IGNORE : qrl_pkg::QRL_PARAM;
              `QRL_CMD_ENTER_QUAD:
                state_reg <= quad_instruction_mode_reg ? qrl_pkg::QRL_IGNORE : qrl_pkg::QRL_WAIT;
              `QRL_CMD_EXIT_QUAD:
                state_reg <= quad_instruction_mode_reg ? qrl_pkg::QRL_WAIT : qrl_pkg::QRL_IGNORE;
              `QRL_CMD_WREN, `QRL_CMD_WRDI, `QRL_CMD_GLOBAL_LOCK, `QRL_CMD_GLOBAL_UNLK,
              `QRL_CMD_RESET_EN, `QRL_CMD_RESET: state_reg <= qrl_pkg::QRL_WAIT;
              default: state_reg <= qrl_pkg::QRL_IGNORE;
            endcase
          end
        end
        qrl_pkg::QRL_ADDR: begin
          if (bit_cnt_next == `QRL_ADDR_BITS) begin
            addr_reg       <= sh_next[23:0];
            dummy_left_reg <= dummy_eff;
            if (cmd_reg == `QRL_CMD_LOCK || cmd_reg == `QRL_CMD_UNLOCK) begin
              state_reg <= qrl_pkg::QRL_WAIT;
            end else if (cmd_reg == `QRL_CMD_READ_LOCK) begin
              state_reg <= qrl_pkg::QRL_DATA;
            end else begin
              state_reg <= qrl_pkg::QRL_DUMMY;
            end
          end
        end
        qrl_pkg::QRL_PARAM: begin
          if ((cmd_reg == `QRL_CMD_SET_PARAM && bit_cnt_next == `QRL_PARAM_BITS) ||
              (cmd_reg == `QRL_CMD_SET_WRAP && bit_cnt_next == `QRL_WRAP_CMD_BITS)) begin
            state_reg <= qrl_pkg::QRL_WAIT;
          end
        end
        qrl_pkg::QRL_DUMMY: begin
          dummy_left_reg <= dummy_left_reg - 4'd1;
          if (dummy_left_reg == 4'd1) begin
            state_reg <= qrl_pkg::QRL_DATA;
          end
        end
        // Extra clocks after a complete frame void it
        qrl_pkg::QRL_WAIT: state_reg <= qrl_pkg::QRL_IGNORE;
        qrl_pkg::QRL_IDLE, qrl_pkg::QRL_DATA, qrl_pkg::QRL_IGNORE: state_reg <= state_reg;
      endcase
    end
  end

  assign array_addr = addr_reg;

  // Command execution happens only when chip select rises on a complete frame
  logic exec;
  assign exec = cs_rise && state_reg == qrl_pkg::QRL_WAIT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quad_instruction_mode_reg <= 1'b0;
      write_enable_latch_reg    <= 1'b0;
      reset_enable_reg          <= 1'b0;
      dummy_cycle_field_reg     <= `QRL_DUMMY_FIELD_RST;
      wrap_length_reg           <= `QRL_WRAP_FIELD_RST;
      lock_reg                  <= '1;
    end else if (exec && cmd_reg == `QRL_CMD_RESET && reset_enable_reg) begin
      quad_instruction_mode_reg <= 1'b0;
      write_enable_latch_reg    <= 1'b0;
      reset_enable_reg          <= 1'b0;
      dummy_cycle_field_reg     <= `QRL_DUMMY_FIELD_RST;
      wrap_length_reg           <= `QRL_WRAP_FIELD_RST;
      lock_reg                  <= '1;
    end else if (cs_rise && state_reg != qrl_pkg::QRL_IDLE) begin
      // Any other frame breaks a pending reset sequence
      reset_enable_reg <= exec && cmd_reg == `QRL_CMD_RESET_EN;
      if (exec) begin
        unique case (cmd_reg)
          `QRL_CMD_WREN: write_enable_latch_reg <= 1'b1;
          `QRL_CMD_WRDI: write_enable_latch_reg <= 1'b0;
          `QRL_CMD_SET_PARAM: begin
            dummy_cycle_field_reg <= sh_reg[`QRL_DUMMY_FIELD_HI:`QRL_DUMMY_FIELD_LO];
            wrap_length_reg       <= sh_reg[`QRL_WRAP_FIELD_HI:`QRL_WRAP_FIELD_LO];
          end
          `QRL_CMD_SET_WRAP: wrap_length_reg <= sh_reg[`QRL_SWRAP_FIELD_HI:`QRL_SWRAP_FIELD_LO];
          // Latch and wrap are untouched by mode changes
          `QRL_CMD_ENTER_QUAD: quad_instruction_mode_reg <= quad_enable_bit;
          `QRL_CMD_EXIT_QUAD: quad_instruction_mode_reg <= 1'b0;
          `QRL_CMD_LOCK: begin
            if (write_enable_latch_reg) begin
              lock_reg[addr_reg[23 -: LOCK_IDX_W]] <= 1'b1;
            end
          end
          `QRL_CMD_UNLOCK: begin
            if (write_enable_latch_reg) begin
              lock_reg[addr_reg[23 -: LOCK_IDX_W]] <= 1'b0;
            end
          end
          `QRL_CMD_GLOBAL_LOCK: begin
            if (write_enable_latch_reg) begin
              lock_reg <= '1;
            end
          end
          `QRL_CMD_GLOBAL_UNLK: begin
            if (write_enable_latch_reg) begin
              lock_reg <= '0;
            end
          end
          default: write_enable_latch_reg <= write_enable_latch_reg;
        endcase
      end
    end
  end

  // Data shifted out MSB first on falling clock edges
  logic [7:0] byte_src;
  assign byte_src = (cmd_reg == `QRL_CMD_READ_LOCK) ?
                    {7'h00, lock_reg[addr_reg[23 -: LOCK_IDX_W]]} : array_rd_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_out       <= 4'h0;
      io_oe_n      <= 4'hf;
      out_sh_reg   <= 8'h00;
      out_left_reg <= 3'd0;
    end else if (state_reg != qrl_pkg::QRL_DATA || cs_n_s2) begin
      io_oe_n      <= 4'hf;
      out_left_reg <= 3'd0;
    end else if (sclk_fall) begin
      io_oe_n <= wide_out ? 4'h0 : 4'hd;
      if (load_byte) begin
        if (wide_out) begin
          io_out       <= byte_src[7:4];
          out_sh_reg   <= {byte_src[3:0], 4'h0};
          out_left_reg <= 3'd4;
        end else begin
          io_out       <= {2'b00, byte_src[7], 1'b0};
          out_sh_reg   <= {byte_src[6:0], 1'b0};
          out_left_reg <= 3'd7;
        end
      end else if (wide_out) begin
        io_out       <= out_sh_reg[7:4];
        out_sh_reg   <= {out_sh_reg[3:0], 4'h0};
        out_left_reg <= out_left_reg - 3'd4;
      end else begin
        io_out       <= {2'b00, out_sh_reg[7], 1'b0};
        out_sh_reg   <= {out_sh_reg[6:0], 1'b0};
        out_left_reg <= out_left_reg - 3'd1;
      end
    end
  end

  // Protection answer for the program/erase side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_locked <= 1'b1;
    end else begin
      prot_locked <= protection_scheme_select ? lock_reg[prot_addr[23 -: LOCK_IDX_W]] : legacy_protected;
    end
  end

  // Six config bits; top bit of the port is spare
  assign legacy_prot_cfg = {1'b0, ctrl_reg[`QRL_CTRL_BLKP_HI:`QRL_CTRL_COMPL]};

  // APB slave, zero wait states
  logic apb_wr, map_hit;
  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign map_hit = paddr == `QRL_OFF_CTRL || paddr == `QRL_OFF_STATUS ||
                   paddr == `QRL_OFF_LOCK_SEL || paddr == `QRL_OFF_LOCK_STAT;
  assign pslverr = psel && penable && !map_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= `QRL_CTRL_RST;
      lock_sel_reg <= '0;
    end else if (apb_wr && paddr == `QRL_OFF_CTRL) begin
      ctrl_reg <= pwdata[7:0];
    end else if (apb_wr && paddr == `QRL_OFF_LOCK_SEL) begin
      lock_sel_reg <= pwdata[LOCK_IDX_W-1:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `QRL_OFF_CTRL: prdata[7:0] = ctrl_reg;
      `QRL_OFF_STATUS: prdata[18:0] = {wrap_bytes, dummy_eff, wrap_length_reg, dummy_cycle_field_reg,
                                       1'b0, reset_enable_reg, write_enable_latch_reg,
                                       quad_instruction_mode_reg};
      `QRL_OFF_LOCK_SEL: prdata[LOCK_IDX_W-1:0] = lock_sel_reg;
      `QRL_OFF_LOCK_STAT: prdata[0] = lock_reg[lock_sel_reg];
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule

//--- verilog/qrl_cfg.svh
// Command codes, register offsets, field positions and defaults of the flash command block
`ifndef QRL_CFG_SVH
`define QRL_CFG_SVH

`define QRL_CMD_WREN        8'h06
`define QRL_CMD_WRDI        8'h04
`define QRL_CMD_SET_PARAM   8'hc0
`define QRL_CMD_SET_WRAP    8'h77
`define QRL_CMD_FAST_READ   8'h0b
`define QRL_CMD_QUAD_IO     8'heb
`define QRL_CMD_WRAP_READ   8'h0c
`define QRL_CMD_ENTER_QUAD  8'h38
`define QRL_CMD_EXIT_QUAD   8'hff
`define QRL_CMD_LOCK        8'h36
`define QRL_CMD_UNLOCK      8'h39
`define QRL_CMD_READ_LOCK   8'h3d
`define QRL_CMD_GLOBAL_LOCK 8'h7e
`define QRL_CMD_GLOBAL_UNLK 8'h98
`define QRL_CMD_RESET_EN    8'h66
`define QRL_CMD_RESET       8'h99

`define QRL_CMD_BITS        6'd8
`define QRL_ADDR_BITS       6'd24
`define QRL_PARAM_BITS      6'd8
`define QRL_WRAP_CMD_BITS   6'd32

`define QRL_DUMMY_BASE      4'd2
`define QRL_SPI_FAST_DUMMY  4'd8
`define QRL_SPI_QIO_DUMMY   4'd6
`define QRL_WRAP_BASE       7'd8

`define QRL_DUMMY_FIELD_HI  5
`define QRL_DUMMY_FIELD_LO  4
`define QRL_WRAP_FIELD_HI   1
`define QRL_WRAP_FIELD_LO   0
`define QRL_SWRAP_FIELD_HI  5
`define QRL_SWRAP_FIELD_LO  4

`define QRL_DUMMY_FIELD_RST 2'h0
`define QRL_WRAP_FIELD_RST  2'h0

`define QRL_OFF_CTRL        12'h000
`define QRL_OFF_STATUS      12'h004
`define QRL_OFF_LOCK_SEL    12'h008
`define QRL_OFF_LOCK_STAT   12'h00c

`define QRL_CTRL_QUAD_EN    0
`define QRL_CTRL_SCHEME     1
`define QRL_CTRL_COMPL      2
`define QRL_CTRL_SECT       3
`define QRL_CTRL_TOP_BOT    4
`define QRL_CTRL_BLKP_LO    5
`define QRL_CTRL_BLKP_HI    7
`define QRL_CTRL_RST        8'h00

`endif

//--- verilog/qrl_pkg.sv
// Types shared by the flash command block
package qrl_pkg;
  typedef enum logic [2:0] {
    QRL_IDLE   = 3'b000,
    QRL_CMD    = 3'b001,
    QRL_ADDR   = 3'b010,
    QRL_PARAM  = 3'b011,
    QRL_DUMMY  = 3'b100,
    QRL_DATA   = 3'b101,
    QRL_WAIT   = 3'b110,
    QRL_IGNORE = 3'b111
  } qrl_state_t;
endpackage

//--- testbench/qrl_flash_cmd_asserts.sv
// Port-level checker for the flash command block
`include "qrl_cfg.svh"
module qrl_flash_cmd_asserts #(
  parameter int LOCK_IDX_W = 8
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial and protection
  input wire logic        cs_n_pin,
  input wire logic [3:0]  io_oe_n,
  input wire logic        legacy_protected,
  input wire logic        prot_locked
);
  logic scheme_q;
  logic acc;
  logic mapped;
  logic st_rd;
  assign acc = psel && penable;
  assign st_rd = acc && !pwrite && paddr == `QRL_OFF_STATUS;
  assign mapped = paddr inside {`QRL_OFF_CTRL, `QRL_OFF_STATUS, `QRL_OFF_LOCK_SEL, `QRL_OFF_LOCK_STAT};
  // Scheme select is not a port, so follow it from bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scheme_q <= 1'b0;
    end else if (acc && pwrite && paddr == `QRL_OFF_CTRL) begin
      scheme_q <= pwdata[`QRL_CTRL_SCHEME];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && !penable |=> pready) else $error("access not answered at once");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
  a_lock_lsb: assert property (acc && !pwrite && paddr == `QRL_OFF_LOCK_STAT |-> prdata[31:1] == 31'h0)
    else $error("lock status beyond bit 0");
  a_dummy_decode: assert property (st_rd && prdata[0] |-> prdata[11:8] == 4'd2 + {1'b0, prdata[5:4], 1'b0})
    else $error("dummy count decode wrong");
  a_wrap_decode: assert property (st_rd |-> prdata[18:12] == (7'd8 << prdata[7:6]))
    else $error("wrap length decode wrong");
  // Sampled reset term keeps the release edge out, where the output still holds its reset value
  a_prot_legacy: assert property (presetn && !scheme_q |=> prot_locked == $past(legacy_protected))
    else $error("legacy protection not followed");
  a_oe_kinds: assert property (io_oe_n inside {4'hf, 4'hd, 4'h0}) else $error("odd output enable pattern");
  a_idle_release: assert property (cs_n_pin [*6] |-> io_oe_n == 4'hf) else $error("pins driven while idle");
endmodule

bind qrl_flash_cmd qrl_flash_cmd_asserts #(.LOCK_IDX_W(LOCK_IDX_W)) i_qrl_flash_cmd_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cs_n_pin(cs_n_pin), .io_oe_n(io_oe_n), .legacy_protected(legacy_protected), .prot_locked(prot_locked));

//--- testbench/qrl_host_model.sv
// Host serial controller model driving select, clock and data pins
module qrl_host_model (
  // Clock
  input  wire logic       pclk,
  // Serial pins
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic [3:0]      io_in,
  input  wire logic [3:0] io_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    io_in    = 4'h5;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Sends nb bits left-aligned in d, then clocks nrd cycles back on io_out[1] or all four lines
  task automatic xfer(input logic [39:0] d, input int nb, input bit quad, input int nrd, output logic [7:0] rd);
    rd = 8'h00;
    cs_n_pin <= 1'b0;
    wt(3);
    for (int i = 0; i < nb; i += (quad ? 4 : 1)) begin
      // Unused lines toggle so a stale level never passes for data
      io_in <= quad ? d[39-i -: 4] : {~io_in[3:1], d[39-i]};
      wt(6);
      sclk_pin <= 1'b1;
      wt(5);
      sclk_pin <= 1'b0;
    end
    for (int i = 0; i < nrd; i++) begin
      io_in <= ~io_in;
      wt(6);
      rd = quad ? {rd[3:0], io_out} : {rd[6:0], io_out[1]};
      sclk_pin <= 1'b1;
      wt(5);
      sclk_pin <= 1'b0;
    end
    wt(1);
    cs_n_pin <= 1'b1;
    io_in <= ~io_in;
    wt(5);
  endtask
endmodule

//--- testbench/qrl_flash_cmd_tb_top.sv
// Self-checking bench for the flash command block
`include "qrl_cfg.svh"
module qrl_flash_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CT = `QRL_OFF_CTRL;
  localparam logic [11:0] ST = `QRL_OFF_STATUS;
  localparam logic [11:0] LS = `QRL_OFF_LOCK_SEL;
  localparam logic [11:0] LK = `QRL_OFF_LOCK_STAT;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cs_n_pin;
  logic        sclk_pin;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe_n;
  logic [23:0] array_addr;
  logic [7:0]  array_rd_data;
  logic [23:0] prot_addr = 24'h050000;
  logic        legacy_protected = 1'b0;
  logic        prot_locked;
  logic [7:0]  rb;
  int          bad_count = 0;
  int          checks = 0;

  always #5 pclk = ~pclk;
  assign array_rd_data = array_addr[7:0] ^ 8'h5a;

  qrl_flash_cmd i_qrl_flash_cmd (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
    .array_addr(array_addr), .array_rd_data(array_rd_data), .prot_addr(prot_addr),
    .legacy_protected(legacy_protected), .prot_locked(prot_locked), .legacy_prot_cfg());
  // Released lines read as pulled up
  qrl_host_model i_qrl_host_model (.pclk(pclk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_in(io_in),
    .io_out(io_out | io_oe_n));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r & m, x);
  endtask
  task automatic cmd(input logic [7:0] c, input bit q);
    i_qrl_host_model.xfer({c, 32'h0}, 8, q, 0, rb);
  endtask
  task automatic acmd(input logic [7:0] c, input int nrd);
    i_qrl_host_model.xfer({c, 24'h050000, 8'h00}, 32, 1'b0, nrd, rb);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic        e;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc("status", ST, 32'h7f0f3, 32'h08000);
    wr(LS, 32'h5);
    rdc("lock bit", LK, 32'h1, 32'h1);
    apb(1'b0, 12'h010, 32'h0, d, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", d, 32'h0);
    $display("test reset done");
    i_qrl_host_model.xfer({8'hc0, 8'h31, 24'h0}, 16, 1'b0, 0, rb);
    rdc("serial param", ST, 32'h7f0f0, 32'h08000);
    i_qrl_host_model.xfer({8'h77, 24'h0, 8'h20}, 40, 1'b0, 0, rb);
    rdc("serial wrap", ST, 32'h7f0c0, 32'h20080);
    i_qrl_host_model.xfer({`QRL_CMD_FAST_READ, 24'h050010, 8'h00}, 32, 1'b0, 16, rb);
    chk("serial fast read", {24'h0, rb}, {24'h0, 8'h10 ^ 8'h5a});
    cmd(`QRL_CMD_ENTER_QUAD, 1'b0);
    rdc("enter no qe", ST, 32'h1, 32'h0);
    cmd(`QRL_CMD_WREN, 1'b0);
    wr(CT, 32'h1);
    cmd(`QRL_CMD_ENTER_QUAD, 1'b0);
    rdc("enter", ST, 32'h7f0c3, 32'h20083);
    for (int f = 0; f < 4; f++) begin
      i_qrl_host_model.xfer({8'hc0, 2'b00, f[1:0], 2'b00, f[1:0], 24'h0}, 16, 1'b1, 0, rb);
      rdc("param", ST, 32'h7fff0, ((8 << f) << 12) | ((2 + 2 * f) << 8) | (f << 6) | (f << 4));
    end
    // 64-byte window: second byte after 0x3e comes from the window start
    i_qrl_host_model.xfer({`QRL_CMD_WRAP_READ, 24'h05003e, 8'h00}, 32, 1'b1, 14, rb);
    chk("wrap read", {24'h0, rb}, {24'h0, 8'h00 ^ 8'h5a});
    cmd(`QRL_CMD_EXIT_QUAD, 1'b1);
    rdc("exit", ST, 32'h7f0c3, 32'h400c2);
    $display("test modes done");
    cmd(`QRL_CMD_WRDI, 1'b0);
    cmd(`QRL_CMD_GLOBAL_UNLK, 1'b0);
    rdc("unlock no latch", LK, 32'h1, 32'h1);
    cmd(`QRL_CMD_WREN, 1'b0);
    cmd(`QRL_CMD_GLOBAL_UNLK, 1'b0);
    rdc("global unlock", LK, 32'h1, 32'h0);
    acmd(`QRL_CMD_LOCK, 0);
    rdc("lock one", LK, 32'h1, 32'h1);
    acmd(`QRL_CMD_READ_LOCK, 8);
    chk("readback locked", {31'h0, rb[0]}, 32'h1);
    wr(LS, 32'h6);
    rdc("neighbour", LK, 32'h1, 32'h0);
    wr(LS, 32'h5);
    acmd(`QRL_CMD_UNLOCK, 0);
    rdc("unlock one", LK, 32'h1, 32'h0);
    acmd(`QRL_CMD_READ_LOCK, 8);
    chk("readback free", {31'h0, rb[0]}, 32'h0);
    wr(CT, 32'h3);
    repeat (3) @(posedge pclk);
    chk("prot unlocked", {31'h0, prot_locked}, 32'h0);
    cmd(`QRL_CMD_GLOBAL_LOCK, 1'b0);
    rdc("global lock", LK, 32'h1, 32'h1);
    chk("prot locked", {31'h0, prot_locked}, 32'h1);
    wr(CT, 32'h1);
    repeat (3) @(posedge pclk);
    chk("prot legacy", {31'h0, prot_locked}, 32'h0);
    $display("test locks done");
    cmd(`QRL_CMD_GLOBAL_UNLK, 1'b0);
    cmd(`QRL_CMD_RESET_EN, 1'b0);
    cmd(`QRL_CMD_RESET, 1'b0);
    rdc("soft reset", ST, 32'h7f0f3, 32'h08000);
    rdc("soft reset lock", LK, 32'h1, 32'h1);
    $display("test soft reset done");
    stop_test();
  end
endmodule
